// file: adccal_consts.svh
// constants for the converter calibration sequencer
`ifndef ADCCAL_CONSTS_SVH
`define ADCCAL_CONSTS_SVH
`define ADCCAL_MD_NORMAL   3'h0
`define ADCCAL_MD_SELF     3'h1
`define ADCCAL_MD_SYS_OFS  3'h2
`define ADCCAL_MD_SYS_FS   3'h3
`define ADCCAL_MD_PSEUDO   3'h4
`define ADCCAL_MD_BACKGND  3'h5
`define ADCCAL_MD_SLEEP    3'h6
`define ADCCAL_CAL_PERIODS 3'h3
`define ADCCAL_SLV_PERIODS 3'h4
`define ADCCAL_FILL_PERIODS 3'h3
`define ADCCAL_ONE_PERIOD  3'h1
`define ADCCAL_CAL_W       24
`define ADCCAL_OFS_RESET   24'h000000
`define ADCCAL_FS_RESET    24'h400000
`endif

// file: adccal_gain.sv
// gain field decode and applied correction of conversion results
`timescale 1ns/1ps
`include "adccal_consts.svh"
module adccal_gain
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic [2:0]               gain_code,
   input  wire logic                     sample_en,
   input  wire logic [`ADCCAL_CAL_W-1:0] raw_sample,
   input  wire logic [`ADCCAL_CAL_W-1:0] ofs_value,
   input  wire logic [`ADCCAL_CAL_W-1:0] fs_value,
   output logic      [4:0]               input_gain_stage,
   output logic      [`ADCCAL_CAL_W-1:0] corrected
);
   logic [4:0]               nxt_gain;
   logic [4:0]               gain_ff;
   logic [`ADCCAL_CAL_W-1:0] nxt_corr;
   logic [`ADCCAL_CAL_W-1:0] corr_ff;
   logic [2*`ADCCAL_CAL_W-1:0] prod;

   // codes above 4 saturate to the top gain of 16
   always_comb
   begin
      case (gain_code)
         3'h0:    nxt_gain = 5'h01;
         3'h1:    nxt_gain = 5'h02;
         3'h2:    nxt_gain = 5'h04;
         3'h3:    nxt_gain = 5'h08;
         default: nxt_gain = 5'h10;
      endcase
      // full-scale word is unity at 0x400000
      prod = (raw_sample - ofs_value) * fs_value;
      nxt_corr = sample_en ? prod[`ADCCAL_CAL_W+21:22] : corr_ff;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         gain_ff <= 5'h01;
         corr_ff <= 24'h000000;
      end
      else
      begin
         gain_ff <= nxt_gain;
         corr_ff <= nxt_corr;
      end
   end

   assign input_gain_stage = gain_ff;
   assign corrected        = corr_ff;

   a_gain_onehot: assert property (@(posedge clk) disable iff (reset)
      $onehot(gain_ff)) else $error("gain not a power of two");
endmodule : adccal_gain

// file: adccal_host_model.sv
// host-side model: paces conversion periods and supplies filter results
`timescale 1ns/1ps
`include "adccal_consts.svh"
module adccal_host_model
#(
   parameter int PERIOD = 6
)
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   output logic                          conv_start,
   output logic      [`ADCCAL_CAL_W-1:0] raw_sample
);
   int     cyc_ff = 0;
   integer seed   = 32'hCB156911;
   initial conv_start = 1'b0;
   initial raw_sample = '0;
   // cadence runs through reset; a fresh sample every period so stale data never matches
   always @(posedge clk)
   begin
      cyc_ff     <= (cyc_ff == PERIOD - 1) ? 0 : cyc_ff + 1;
      conv_start <= (cyc_ff == PERIOD - 1);
      if (conv_start)
         raw_sample <= $random(seed);
   end
endmodule : adccal_host_model

// file: adccal_pkg.sv
// types for the converter calibration sequencer
package adccal_pkg;
   typedef enum logic [2:0]
   {
      ADCCAL_IDLE   = 3'h0,
      ADCCAL_OFS    = 3'h1,
      ADCCAL_FS     = 3'h3,
      ADCCAL_FILL   = 3'h2,
      ADCCAL_SLEEP  = 3'h6
   } adccal_state_t;
   typedef logic [2:0] adccal_mode_t;
endpackage : adccal_pkg

// file: adccal_seq.sv
// calibration sequencer: mode decode, phase timing, data-valid gating
`timescale 1ns/1ps
`include "adccal_consts.svh"
module adccal_seq
   import adccal_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     conv_start,
   input  wire logic                     slave_mode,
   input  wire logic                     mode_wr,
   input  wire adccal_pkg::adccal_mode_t mode_wdata,
   input  wire logic [2:0]               gain_code,
   input  wire logic [`ADCCAL_CAL_W-1:0] raw_sample,
   input  wire logic                     ofs_wr,
   input  wire logic                     fs_wr,
   input  wire logic [`ADCCAL_CAL_W-1:0] cal_wdata,
   output logic      [2:0]               op_mode_field,
   output logic                          data_valid_n,
   output logic                          inputs_shorted,
   output logic                          input_on_ref,
   output logic                          sleeping,
   output logic      [4:0]               input_gain_stage,
   output logic      [`ADCCAL_CAL_W-1:0] ofs_cal_reg,
   output logic      [`ADCCAL_CAL_W-1:0] fs_cal_reg,
   output logic      [`ADCCAL_CAL_W-1:0] corrected
);
   import adccal_pkg::*;

   adccal_state_t            state_ff, nxt_state;
   adccal_mode_t             mode_ff, nxt_mode;
   logic [2:0]               cnt_ff, nxt_cnt;
   logic                     pend_ff, nxt_pend;
   logic                     first_ff, nxt_first;
   logic                     data_valid_n_n_ff, nxt_data_valid_n_n;
   logic                     short_ff, nxt_short;
   logic                     ref_ff, nxt_ref;
   logic [`ADCCAL_CAL_W-1:0] ofs_ff, nxt_ofs;
   logic [`ADCCAL_CAL_W-1:0] fs_ff, nxt_fs;
   logic [2:0]               ofs_len;
   logic                     last;

   assign last = (cnt_ff == `ADCCAL_ONE_PERIOD);

   always_comb
   begin
      nxt_state  = state_ff;
      nxt_mode   = mode_ff;
      nxt_cnt    = cnt_ff;
      nxt_pend   = pend_ff;
      nxt_first  = first_ff;
      nxt_data_valid_n_n = data_valid_n_n_ff;
      nxt_short  = short_ff;
      nxt_ref    = ref_ff;
      nxt_ofs    = ofs_ff;
      nxt_fs     = fs_ff;
      // only the first offset phase (or system full-scale phase) after a mode write takes the slave extra period
      ofs_len = (slave_mode && first_ff) ? `ADCCAL_SLV_PERIODS : `ADCCAL_CAL_PERIODS;
      if (mode_wr)
      begin
         nxt_mode  = mode_wdata;
         nxt_pend  = 1'b1;
         nxt_first = 1'b1;
      end
      if (conv_start)
      begin
         nxt_data_valid_n_n = 1'b1;
         if (pend_ff)
         begin
            nxt_pend = 1'b0;
            nxt_short = 1'b0;
            nxt_ref   = 1'b0;
            case (mode_ff)
               `ADCCAL_MD_SELF, `ADCCAL_MD_BACKGND:
               begin
                  nxt_state = ADCCAL_OFS;
                  nxt_cnt   = ofs_len;
                  nxt_short = 1'b1;
               end
               `ADCCAL_MD_SYS_OFS, `ADCCAL_MD_PSEUDO:
               begin
                  nxt_state = ADCCAL_OFS;
                  nxt_cnt   = ofs_len;
               end
               `ADCCAL_MD_SYS_FS:
               begin
                  nxt_state = ADCCAL_FS;
                  nxt_cnt   = ofs_len;
               end
               `ADCCAL_MD_SLEEP: nxt_state = ADCCAL_SLEEP;
               default: nxt_state = ADCCAL_IDLE;
            endcase
         end
         else
         begin
            case (state_ff)
               ADCCAL_IDLE: nxt_data_valid_n_n = 1'b0;
               ADCCAL_OFS:
               begin
                  nxt_cnt = cnt_ff - `ADCCAL_ONE_PERIOD;
                  if (last)
                  begin
                     nxt_ofs   = raw_sample;
                     nxt_first = 1'b0;
                     nxt_short = 1'b0;
                     if (mode_ff == `ADCCAL_MD_SYS_OFS)
                     begin
                        nxt_mode  = `ADCCAL_MD_NORMAL;
                        nxt_state = ADCCAL_FILL;
                        nxt_cnt   = `ADCCAL_ONE_PERIOD;
                     end
                     else if (mode_ff == `ADCCAL_MD_BACKGND)
                     begin
                        nxt_state = ADCCAL_FILL;
                        nxt_cnt   = `ADCCAL_FILL_PERIODS;
                     end
                     else
                     begin
                        nxt_state = ADCCAL_FS;
                        nxt_ref   = 1'b1;
                        nxt_cnt   = `ADCCAL_CAL_PERIODS;
                     end
                  end
               end
               ADCCAL_FS:
               begin
                  nxt_cnt = cnt_ff - `ADCCAL_ONE_PERIOD;
                  if (last)
                  begin
                     nxt_fs    = raw_sample;
                     nxt_ref   = 1'b0;
                     nxt_state = ADCCAL_FILL;
                     if (mode_ff == `ADCCAL_MD_SYS_FS)
                     begin
                        nxt_mode = `ADCCAL_MD_NORMAL;
                        nxt_cnt  = `ADCCAL_ONE_PERIOD;
                     end
                     else
                     begin
                        if (mode_ff != `ADCCAL_MD_BACKGND)
                           nxt_mode = `ADCCAL_MD_NORMAL;
                        nxt_cnt = `ADCCAL_FILL_PERIODS;
                     end
                  end
               end
               ADCCAL_FILL:
               begin
                  nxt_cnt = cnt_ff - `ADCCAL_ONE_PERIOD;
                  if (last)
                  begin
                     nxt_data_valid_n_n = 1'b0;
                     nxt_state  = ADCCAL_IDLE;
                     if (mode_ff == `ADCCAL_MD_BACKGND)
                        nxt_pend = 1'b1;
                  end
               end
               ADCCAL_SLEEP: nxt_data_valid_n_n = 1'b1;
               default: nxt_state = ADCCAL_IDLE;
            endcase
         end
      end
      // host writes land after the sequencer's own result
      if (ofs_wr)
         nxt_ofs = cal_wdata;
      if (fs_wr)
         nxt_fs = cal_wdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_ff  <= ADCCAL_IDLE;
         mode_ff   <= `ADCCAL_MD_NORMAL;
         cnt_ff    <= 3'h0;
         pend_ff   <= 1'b0;
         first_ff  <= 1'b0;
         data_valid_n_n_ff <= 1'b1;
         short_ff  <= 1'b0;
         ref_ff    <= 1'b0;
         ofs_ff    <= `ADCCAL_OFS_RESET;
         fs_ff     <= `ADCCAL_FS_RESET;
      end
      else
      begin
         state_ff  <= nxt_state;
         mode_ff   <= nxt_mode;
         cnt_ff    <= nxt_cnt;
         pend_ff   <= nxt_pend;
         first_ff  <= nxt_first;
         data_valid_n_n_ff <= nxt_data_valid_n_n;
         short_ff  <= nxt_short;
         ref_ff    <= nxt_ref;
         ofs_ff    <= nxt_ofs;
         fs_ff     <= nxt_fs;
      end
   end

   adccal_gain u_gain
   (
      .clk              (clk),
      .reset            (reset),
      .gain_code        (gain_code),
      .sample_en        (conv_start),
      .raw_sample       (raw_sample),
      .ofs_value        (ofs_ff),
      .fs_value         (fs_ff),
      .input_gain_stage (input_gain_stage),
      .corrected        (corrected)
   );

   assign op_mode_field  = mode_ff;
   assign data_valid_n   = data_valid_n_n_ff;
   assign inputs_shorted = short_ff;
   assign input_on_ref   = ref_ff;
   assign sleeping       = (state_ff == ADCCAL_SLEEP);
   assign ofs_cal_reg    = ofs_ff;
   assign fs_cal_reg     = fs_ff;

   sequence s_cal_busy;
      state_ff inside {ADCCAL_OFS, ADCCAL_FS, ADCCAL_FILL};
   endsequence

   a_busy_no_valid: assert property (@(posedge clk) disable iff (reset)
      s_cal_busy |-> data_valid_n) else $error("data valid during calibration");
   a_self_shorts: assert property (@(posedge clk) disable iff (reset)
      (conv_start && pend_ff && mode_ff == `ADCCAL_MD_SELF) |=> inputs_shorted
      && state_ff == ADCCAL_OFS) else $error("self cal did not short inputs");
   a_ofs_length: assert property (@(posedge clk) disable iff (reset)
      (state_ff == ADCCAL_OFS && !pend_ff) |-> cnt_ff <= `ADCCAL_SLV_PERIODS)
      else $error("offset phase too long");
   a_ref_in_fs: assert property (@(posedge clk) disable iff (reset)
      input_on_ref |-> state_ff == ADCCAL_FS) else $error("reference outside fs");
   a_sysofs_clear: assert property (@(posedge clk) disable iff (reset)
      (conv_start && !pend_ff && state_ff == ADCCAL_OFS && last
      && mode_ff == `ADCCAL_MD_SYS_OFS) |=> op_mode_field == `ADCCAL_MD_NORMAL
      && cnt_ff == `ADCCAL_ONE_PERIOD) else $error("sys offset end wrong");
   a_sysfs_clear: assert property (@(posedge clk) disable iff (reset)
      (conv_start && !pend_ff && state_ff == ADCCAL_FS && last
      && mode_ff == `ADCCAL_MD_SYS_FS && !mode_wr) |=> op_mode_field
      == `ADCCAL_MD_NORMAL) else $error("sys fs end wrong");
   a_bg_persists: assert property (@(posedge clk) disable iff (reset)
      (mode_ff == `ADCCAL_MD_BACKGND && !mode_wr) |=> mode_ff == `ADCCAL_MD_BACKGND)
      else $error("background mode left on its own");
   a_host_ofs_write: assert property (@(posedge clk) disable iff (reset)
      ofs_wr |=> ofs_cal_reg == $past(cal_wdata)) else $error("offset write lost");
   a_fill_valid: assert property (@(posedge clk) disable iff (reset)
      (conv_start && !pend_ff && state_ff == ADCCAL_FILL && last) |=> !data_valid_n)
      else $error("valid not raised after fill");
endmodule : adccal_seq

// file: tb_top.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
`include "adccal_consts.svh"
module tb_top;
   import adccal_pkg::*;
   typedef struct {int n; logic [2:0] md;} adccal_note_t;
   logic                     clk, reset, conv_start, slave_mode, mode_wr, ofs_wr, fs_wr;
   logic                     data_valid_n, inputs_shorted, input_on_ref, sleeping;
   adccal_mode_t             mode_wdata;
   logic [2:0]               gain_code, op_mode_field;
   logic [4:0]               input_gain_stage;
   logic [`ADCCAL_CAL_W-1:0] raw_sample, cal_wdata, ofs_cal_reg, fs_cal_reg, corrected, v, r;
   logic [`ADCCAL_CAL_W-1:0] raws [0:15];
   int                       errors = 0, checked = 0, cycles = 0, cnt = 0;
   logic                     armed = 0, done = 0, last_n = 1;
   integer                   seed = 32'hCB156911;
   adccal_note_t             notes[$], note;

   adccal_seq u_adccal_seq (.clk(clk), .reset(reset), .conv_start(conv_start),
      .slave_mode(slave_mode), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .gain_code(gain_code), .raw_sample(raw_sample), .ofs_wr(ofs_wr), .fs_wr(fs_wr),
      .cal_wdata(cal_wdata), .op_mode_field(op_mode_field), .data_valid_n(data_valid_n),
      .inputs_shorted(inputs_shorted), .input_on_ref(input_on_ref), .sleeping(sleeping),
      .input_gain_stage(input_gain_stage), .ofs_cal_reg(ofs_cal_reg),
      .fs_cal_reg(fs_cal_reg), .corrected(corrected));
   adccal_host_model u_adccal_host_model (.clk(clk), .reset(reset),
      .conv_start(conv_start), .raw_sample(raw_sample));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         errors++;
         finish_test;
      end
   end

   // counts conversion periods from the mode write to the first data-valid fall
   always @(posedge clk)
   begin
      last_n <= data_valid_n;
      if (armed && conv_start)
      begin
         cnt = cnt + 1;
         raws[cnt[3:0]] = raw_sample;
      end
      if (armed && last_n === 1'b1 && data_valid_n === 1'b0)
      begin
         note = notes.pop_front();
         check(cnt, note.n, "periods to data valid");
         check(op_mode_field, note.md, "mode after sequence");
         armed = 0;
         done = 1;
      end
   end

   // write lands between conversion starts so the next start is unambiguous
   task automatic set_mode(input adccal_mode_t code, input logic arm);
      @(posedge clk iff conv_start);
      mode_wdata <= code;
      mode_wr <= 1'b1;
      done = 0;
      @(posedge clk);
      mode_wr <= 1'b0;
      if (arm)
      begin
         cnt = 0;
         armed = 1;
      end
      repeat (2) @(posedge clk);
   endtask : set_mode

   task automatic run_cal(input adccal_mode_t code, input logic slv, input int n);
      int t;
      slave_mode <= slv;
      notes.push_back('{n, (code == `ADCCAL_MD_BACKGND) ? code : `ADCCAL_MD_NORMAL});
      set_mode(code, 1'b1);
      for (t = 0; t < 200 && !done; t++)
         @(posedge clk);
      check(done, 1'b1, "sequence finished");
   endtask : run_cal

   task automatic host_wr(input logic is_fs, input logic [`ADCCAL_CAL_W-1:0] d);
      cal_wdata <= d;
      ofs_wr <= !is_fs;
      fs_wr <= is_fs;
      @(posedge clk);
      ofs_wr <= 1'b0;
      fs_wr <= 1'b0;
      @(posedge clk);
   endtask : host_wr

   initial
   begin
      reset = 1'b1;
      slave_mode = 1'b0;
      mode_wr = 1'b0;
      mode_wdata = `ADCCAL_MD_NORMAL;
      gain_code = 3'h0;
      ofs_wr = 1'b0;
      fs_wr = 1'b0;
      cal_wdata = '0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      check(ofs_cal_reg, `ADCCAL_OFS_RESET, "offset reset");
      check(fs_cal_reg, `ADCCAL_FS_RESET, "full-scale reset");
      check(op_mode_field, `ADCCAL_MD_NORMAL, "mode reset");
      check(data_valid_n, 1'b1, "data valid reset");
      for (int g = 0; g < 8; g++)
      begin
         @(posedge clk);
         gain_code <= g[2:0];
         repeat (3) @(posedge clk);
         check(input_gain_stage, 5'h01 << ((g > 4) ? 4 : g), "gain stage");
      end
      v = $random(seed);
      host_wr(1'b0, v);
      host_wr(1'b1, `ADCCAL_FS_RESET);
      check(ofs_cal_reg, v, "host offset kept");
      check(fs_cal_reg, `ADCCAL_FS_RESET, "host full-scale kept");
      @(posedge clk iff conv_start);
      r = raw_sample;
      repeat (2) @(posedge clk);
      check(corrected, 24'(r - v), "corrected result");
      // gain was changed above, so recalibrate before trusting data
      run_cal(`ADCCAL_MD_SELF, 1'b0, 10);
      check(ofs_cal_reg, raws[4], "self offset result");
      check(fs_cal_reg, raws[7], "self full-scale result");
      run_cal(`ADCCAL_MD_SELF, 1'b1, 11);
      run_cal(`ADCCAL_MD_SYS_OFS, 1'b0, 5);
      run_cal(`ADCCAL_MD_SYS_FS, 1'b0, 5);
      run_cal(`ADCCAL_MD_SYS_OFS, 1'b1, 6);
      run_cal(`ADCCAL_MD_SYS_FS, 1'b1, 6);
      run_cal(`ADCCAL_MD_PSEUDO, 1'b0, 10);
      run_cal(`ADCCAL_MD_BACKGND, 1'b0, 7);
      repeat (150) @(posedge clk);
      check(op_mode_field, `ADCCAL_MD_BACKGND, "background persists");
      // a new mode only takes effect at the next conversion start
      set_mode(`ADCCAL_MD_SLEEP, 1'b0);
      @(posedge clk iff conv_start);
      @(posedge clk);
      check(sleeping, 1'b1, "sleep entered");
      set_mode(`ADCCAL_MD_NORMAL, 1'b0);
      @(posedge clk iff conv_start);
      @(posedge clk);
      check(sleeping, 1'b0, "sleep left");
      finish_test;
   end
endmodule : tb_top
